// >>> rtl/adcc_calc.sv
// arithmetic unit: justification, accumulate, filter, setpoint error, thresholds
`timescale 1ns/100ps
module adcc_calc (
    // link to the register block
    adcc_calc_if.calc_unit c
);
    logic [16:0] sum;
    logic [15:0] decay;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [16:0] diff;

    always_comb begin
        // justification of a fresh sample
        if (c.fmt) begin
            c.result = {6'h00, c.sample}; // RULE7
        end else begin
            c.result = {c.sample, 6'h00}; // RULE8
        end
        decay = c.acc >> c.shift;
        sum   = 17'h0_0000;
        case (adcc_pkg::adcc_mode_t'(c.mode))
            adcc_pkg::mode_accumulate, adcc_pkg::mode_average,
            adcc_pkg::mode_burst_average: begin
                sum = {1'b0, c.acc} + {7'h00, c.sample};
                c.next_acc    = sum[15:0];
                c.acc_ovf     = sum[16];
                c.next_filter = sum[15:0] >> c.shift; // RULE4
            end
            adcc_pkg::mode_low_pass: begin
                // first-order filter: acc - acc/2^n + sample, output scaled back
                sum = {1'b0, c.acc} - {1'b0, decay} + {7'h00, c.sample};
                c.next_acc    = sum[15:0];
                c.acc_ovf     = sum[16];
                c.next_filter = sum[15:0] >> c.shift; // RULE5
            end
            default: begin
                c.next_acc    = c.acc;
                c.acc_ovf     = 1'b0;
                c.next_filter = c.filter;
            end
        endcase
        case (adcc_pkg::adcc_calc_t'(c.calc))
            adcc_pkg::calc_result_minus_prev: begin
                opa = c.result;
                opb = c.prev;
            end
            adcc_pkg::calc_result_minus_setpoint: begin
                opa = c.result;
                opb = c.setpoint; // RULE14
            end
            adcc_pkg::calc_filter_minus_setpoint: begin
                opa = c.next_filter;
                opb = c.setpoint;
            end
            default: begin
                opa = c.prev;
                opb = c.next_filter;
            end
        endcase
        diff      = {opa[15], opa} - {opb[15], opb}; // RULE15
        c.err     = diff[15:0];
        c.err_ovf = diff[16] ^ diff[15]; // RULE21
        c.above   = $signed(diff[15:0]) > $signed(c.upper); // RULE19
        c.below   = $signed(diff[15:0]) < $signed(c.lower); // RULE20
    end
endmodule

// >>> rtl/adcc_calc_if.sv
// signals between the register block and its arithmetic unit
`timescale 1ns/100ps
interface adcc_calc_if;
    logic [2:0]  mode;
    logic [2:0]  shift;
    logic [1:0]  calc;
    logic        fmt;
    logic [9:0]  sample;
    logic [15:0] acc;
    logic [15:0] filter;
    logic [15:0] prev;
    logic [15:0] setpoint;
    logic [15:0] lower;
    logic [15:0] upper;
    logic [15:0] result;
    logic [15:0] next_acc;
    logic [15:0] next_filter;
    logic [15:0] err;
    logic        acc_ovf;
    logic        err_ovf;
    logic        above;
    logic        below;

    modport core (
        output mode, shift, calc, fmt, sample, acc, filter, prev, setpoint, lower, upper,
        input  result, next_acc, next_filter, err, acc_ovf, err_ovf, above, below
    );
    modport calc_unit (
        input  mode, shift, calc, fmt, sample, acc, filter, prev, setpoint, lower, upper,
        output result, next_acc, next_filter, err, acc_ovf, err_ovf, above, below
    );
endinterface

// >>> rtl/adcc_defs.svh
// register indices, field positions and reset values of the converter computation block
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
// Function
// [RULE1] 8-bit repeat counter advances once per conversion trigger before the threshold check.
// [RULE2] threshold check happens when the repeat counter reaches the repeat setting.
// [RULE3] counter and repeat setting only used in low-pass, burst average, average modes.
// [RULE4] accumulate/average/burst average: filter output is accumulator shifted right by select.
// [RULE5] low-pass mode: filter output presents the low-pass filter result.
// [RULE6] filter output is 16-bit read-only, high and low byte, undefined after reset; here reset clears it to zero.
// [RULE7] format bit set: right-justified, high byte holds only top two result bits.
// [RULE8] format bit clear: left-justified, low byte holds lowest two bits on top.
// [RULE9] source select set: previous result takes filter output at conversion start.
// [RULE10] source select clear: previous result takes justified result at conversion start.
// [RULE11] previous result is 16-bit, read-only, cleared by reset.
// [RULE12] accumulator undefined at power-up, untouched by other resets.
// [RULE13] accumulator readable and writable through its high and low bytes.
// [RULE14] 16-bit writable setpoint, reset zero, used by error calc when selected.
// [RULE15] 16-bit read-only setpoint error, reset zero, formula from error calc select.
// [RULE16] error compared with lower and upper thresholds, updating both status flags.
// [RULE17] threshold event raised only when threshold interrupt mode selects the outcome.
// [RULE18] 5-bit auto trigger select picks one of 32 hardware trigger sources.
// [RULE19] above-upper flag set when error exceeds upper threshold, else cleared.
// [RULE20] below-lower flag set when error is under lower threshold, else cleared.
// [RULE21] overflow flag set when accumulator or error calculation overflows.
// [RULE22] each 16-bit register is two byte locations, low byte first.

// -----------------------------------------------------------------------------
// register indices (byte address = 4 * index)
// -----------------------------------------------------------------------------
`define ADCC_IDX_TRIG  14'h0f51
`define ADCC_IDX_PREV  14'h0f5c
`define ADCC_IDX_RES   14'h0f5e
`define ADCC_IDX_RPT   14'h0f61
`define ADCC_IDX_CNT   14'h0f62
`define ADCC_IDX_STPT  14'h0f63
`define ADCC_IDX_LTH   14'h0f65
`define ADCC_IDX_UTH   14'h0f67
`define ADCC_IDX_ERR   14'h0f69
`define ADCC_IDX_ACC   14'h0f6b
`define ADCC_IDX_FLTR  14'h0f6d
`define ADCC_IDX_CTRL0 14'h0f70
`define ADCC_IDX_CTRL1 14'h0f71
`define ADCC_IDX_TMD   14'h0f72
`define ADCC_IDX_STAT  14'h0f73

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define ADCC_CTRL0_FMT  7
`define ADCC_CTRL0_PSIS 6
`define ADCC_CTRL1_CALC 4
`define ADCC_STAT_OVF   7
`define ADCC_STAT_ABOVE 6
`define ADCC_STAT_BELOW 5
`define ADCC_STAT_MATH  4

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define ADCC_RST8  8'h00
`define ADCC_RST16 16'h0000
`define ADCC_RST32 32'h0000_0000
`endif

// >>> rtl/adcc_pkg.sv
// types shared by the converter computation block
package adcc_pkg;
    typedef enum logic [2:0] {
        mode_basic,
        mode_accumulate,
        mode_average,
        mode_burst_average,
        mode_low_pass
    } adcc_mode_t;

    typedef enum logic [1:0] {
        calc_result_minus_prev,
        calc_result_minus_setpoint,
        calc_filter_minus_setpoint,
        calc_prev_minus_filter
    } adcc_calc_t;

    typedef enum logic [2:0] {
        tmd_never,
        tmd_below,
        tmd_above,
        tmd_inside,
        tmd_outside,
        tmd_always
    } adcc_tmd_t;
endpackage

// >>> rtl/adcc_regs.sv
// converter computation and result registers behind an apb slave
`timescale 1ns/100ps
`include "adcc_defs.svh"
module adcc_regs (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [15:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // conversion core
    input  wire logic        conv_start,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_sample,
    // trigger sources and selected trigger
    input  wire logic [31:0] trig_src,
    output logic             auto_trigger,
    // threshold event
    output logic             threshold_event
);
    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [4:0]  trig_sel;
        logic [7:0]  rpt;
        logic [7:0]  cnt;
        logic [15:0] prev;
        logic [15:0] result;
        logic [15:0] setpoint;
        logic [15:0] lower;
        logic [15:0] upper;
        logic [15:0] err;
        logic [15:0] filter;
        logic [2:0]  mode;
        logic        fmt;
        logic        psis;
        logic [2:0]  shift;
        logic [1:0]  calc;
        logic [2:0]  tmd;
        logic        ovf;
        logic        above;
        logic        below;
        logic        math;
        logic        trig_q;
        logic        trig_out;
        logic        event_out;
        logic        ready;
        logic        err_resp;
        logic [31:0] rdata;
    } adcc_state_t;

    adcc_state_t s;
    adcc_state_t next_s;
    logic [15:0] acc;
    logic [15:0] next_acc;

    adcc_calc_if cif ();

    adcc_calc u_calc (
        .c (cif.calc_unit)
    );

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    function automatic logic in16(input logic [13:0] idx, input logic [13:0] base);
        in16 = (idx == base) || (idx == base + 14'h0001); // RULE22
    endfunction

    function automatic logic [7:0] rd16(input logic [15:0] v, input logic [13:0] idx,
                                        input logic [13:0] base);
        rd16 = (idx == base) ? v[7:0] : v[15:8];
    endfunction

    function automatic logic [15:0] wr16(input logic [15:0] v, input logic [13:0] idx,
                                         input logic [13:0] base, input logic [7:0] b);
        wr16 = (idx == base) ? {v[15:8], b} : {b, v[7:0]};
    endfunction

    function automatic logic mapped(input logic [13:0] idx);
        mapped = (idx == `ADCC_IDX_TRIG) || (idx == `ADCC_IDX_RPT)
              || (idx == `ADCC_IDX_CNT)  || (idx == `ADCC_IDX_CTRL0)
              || (idx == `ADCC_IDX_CTRL1) || (idx == `ADCC_IDX_TMD)
              || (idx == `ADCC_IDX_STAT) || in16(idx, `ADCC_IDX_PREV)
              || in16(idx, `ADCC_IDX_RES) || in16(idx, `ADCC_IDX_STPT)
              || in16(idx, `ADCC_IDX_LTH) || in16(idx, `ADCC_IDX_UTH)
              || in16(idx, `ADCC_IDX_ERR) || in16(idx, `ADCC_IDX_ACC)
              || in16(idx, `ADCC_IDX_FLTR);
    endfunction

    // -------------------------------------------------------------------------
    // arithmetic unit hookup
    // -------------------------------------------------------------------------
    assign cif.mode     = s.mode;
    assign cif.shift    = s.shift;
    assign cif.calc     = s.calc;
    assign cif.fmt      = s.fmt;
    assign cif.sample   = conv_sample;
    assign cif.acc      = acc;
    assign cif.filter   = s.filter;
    assign cif.prev     = s.prev;
    assign cif.setpoint = s.setpoint;
    assign cif.lower    = s.lower;
    assign cif.upper    = s.upper;

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    logic [13:0] idx;
    logic        setup;
    logic        wr_take;
    logic [7:0]  wb;
    logic [7:0]  rb;
    logic        cnt_mode;
    logic        acc_mode;
    logic        check;
    logic        hit;
    logic [7:0]  cnt_inc;
    logic        sel_trig;

    always_comb begin
        next_s   = s;
        next_acc = acc;
        idx      = paddr[15:2];
        setup    = psel && !penable;
        wr_take  = psel && penable && s.ready && pwrite;
        wb       = pwdata[7:0];
        rb       = `ADCC_RST8;
        check    = 1'b0;
        hit      = 1'b0;
        cnt_inc  = s.cnt + 8'h01;
        cnt_mode = (s.mode == adcc_pkg::mode_average)
                || (s.mode == adcc_pkg::mode_burst_average)
                || (s.mode == adcc_pkg::mode_low_pass); // RULE3
        acc_mode = cnt_mode || (s.mode == adcc_pkg::mode_accumulate);

        // read data is captured in the setup cycle so prdata leaves a flop
        if (idx == `ADCC_IDX_TRIG) begin
            rb = {3'h0, s.trig_sel};
        end else if (idx == `ADCC_IDX_RPT) begin
            rb = s.rpt;
        end else if (idx == `ADCC_IDX_CNT) begin
            rb = s.cnt;
        end else if (idx == `ADCC_IDX_CTRL0) begin
            rb = {s.fmt, s.psis, 3'h0, s.mode};
        end else if (idx == `ADCC_IDX_CTRL1) begin
            rb = {2'h0, s.calc, 1'b0, s.shift};
        end else if (idx == `ADCC_IDX_TMD) begin
            rb = {5'h00, s.tmd};
        end else if (idx == `ADCC_IDX_STAT) begin
            rb = {s.ovf, s.above, s.below, s.math, 4'h0};
        end else if (in16(idx, `ADCC_IDX_PREV)) begin
            rb = rd16(s.prev, idx, `ADCC_IDX_PREV);
        end else if (in16(idx, `ADCC_IDX_RES)) begin
            rb = rd16(s.result, idx, `ADCC_IDX_RES);
        end else if (in16(idx, `ADCC_IDX_STPT)) begin
            rb = rd16(s.setpoint, idx, `ADCC_IDX_STPT);
        end else if (in16(idx, `ADCC_IDX_LTH)) begin
            rb = rd16(s.lower, idx, `ADCC_IDX_LTH);
        end else if (in16(idx, `ADCC_IDX_UTH)) begin
            rb = rd16(s.upper, idx, `ADCC_IDX_UTH);
        end else if (in16(idx, `ADCC_IDX_ERR)) begin
            rb = rd16(s.err, idx, `ADCC_IDX_ERR);
        end else if (in16(idx, `ADCC_IDX_ACC)) begin
            rb = rd16(acc, idx, `ADCC_IDX_ACC); // RULE13
        end else if (in16(idx, `ADCC_IDX_FLTR)) begin
            rb = rd16(s.filter, idx, `ADCC_IDX_FLTR); // RULE6
        end

        next_s.ready    = setup;
        next_s.err_resp = setup && !mapped(idx);
        next_s.rdata    = (setup && !pwrite) ? {24'h00_0000, rb} : `ADCC_RST32;

        // software writes; read-only locations ignore them
        if (wr_take) begin
            if (idx == `ADCC_IDX_TRIG) begin
                next_s.trig_sel = wb[4:0]; // RULE18
            end else if (idx == `ADCC_IDX_RPT) begin
                next_s.rpt = wb;
            end else if (idx == `ADCC_IDX_CNT) begin
                next_s.cnt = wb;
            end else if (idx == `ADCC_IDX_CTRL0) begin
                next_s.fmt  = wb[`ADCC_CTRL0_FMT];
                next_s.psis = wb[`ADCC_CTRL0_PSIS];
                next_s.mode = wb[2:0];
            end else if (idx == `ADCC_IDX_CTRL1) begin
                next_s.calc  = wb[`ADCC_CTRL1_CALC +: 2];
                next_s.shift = wb[2:0];
            end else if (idx == `ADCC_IDX_TMD) begin
                next_s.tmd = wb[2:0];
            end else if (idx == `ADCC_IDX_STAT) begin
                // write one to clear; a hardware set below still wins
                if (wb[`ADCC_STAT_OVF]) begin
                    next_s.ovf = 1'b0;
                end
                if (wb[`ADCC_STAT_MATH]) begin
                    next_s.math = 1'b0;
                end
            end else if (in16(idx, `ADCC_IDX_RES)) begin
                next_s.result = wr16(s.result, idx, `ADCC_IDX_RES, wb);
            end else if (in16(idx, `ADCC_IDX_STPT)) begin
                next_s.setpoint = wr16(s.setpoint, idx, `ADCC_IDX_STPT, wb); // RULE14
            end else if (in16(idx, `ADCC_IDX_LTH)) begin
                next_s.lower = wr16(s.lower, idx, `ADCC_IDX_LTH, wb);
            end else if (in16(idx, `ADCC_IDX_UTH)) begin
                next_s.upper = wr16(s.upper, idx, `ADCC_IDX_UTH, wb);
            end else if (in16(idx, `ADCC_IDX_ACC)) begin
                next_acc = wr16(acc, idx, `ADCC_IDX_ACC, wb); // RULE13
            end
        end

        // previous result snapshot at the start of a conversion
        if (conv_start) begin
            if (s.psis) begin
                next_s.prev = s.filter; // RULE9
            end else begin
                next_s.prev = s.result; // RULE10
            end
        end

        // a finished conversion updates result, accumulator and counter
        if (conv_done) begin
            next_s.result = cif.result;
            if (cnt_mode) begin
                next_s.cnt = cnt_inc; // RULE1
                if (cnt_inc == s.rpt) begin
                    check      = 1'b1; // RULE2
                    next_s.cnt = `ADCC_RST8;
                end
            end else begin
                check = 1'b1;
            end
            if (acc_mode) begin
                next_acc      = cif.next_acc;
                next_s.filter = cif.next_filter; // RULE4
                next_s.math   = 1'b1;
                if (cif.acc_ovf) begin
                    next_s.ovf = 1'b1; // RULE21
                end
            end
            // averages restart after each check; the low-pass keeps its history
            if (check && (s.mode == adcc_pkg::mode_average
                          || s.mode == adcc_pkg::mode_burst_average)) begin
                next_acc = `ADCC_RST16;
            end
        end

        // threshold evaluation
        if (check) begin
            next_s.err   = cif.err; // RULE15
            next_s.above = cif.above; // RULE16 RULE19
            next_s.below = cif.below; // RULE16 RULE20
            if (cif.err_ovf) begin
                next_s.ovf = 1'b1; // RULE21
            end
            case (adcc_pkg::adcc_tmd_t'(s.tmd))
                adcc_pkg::tmd_below:   hit = cif.below;
                adcc_pkg::tmd_above:   hit = cif.above;
                adcc_pkg::tmd_inside:  hit = !cif.below && !cif.above;
                adcc_pkg::tmd_outside: hit = cif.below || cif.above;
                adcc_pkg::tmd_always:  hit = 1'b1;
                default:               hit = 1'b0;
            endcase
        end
        next_s.event_out = hit; // RULE17

        // selected trigger source, rising edge passed on as one pulse
        sel_trig        = trig_src[s.trig_sel]; // RULE18
        next_s.trig_q   = sel_trig;
        next_s.trig_out = sel_trig && !s.trig_q;
    end

    // -------------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0; // RULE11
        end else begin
            s <= next_s;
        end
    end

    // no reset: power-up contents are unknown and system resets keep them
    always_ff @(posedge pclk) begin
        acc <= next_acc; // RULE12
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign prdata          = s.rdata;
    assign pready          = s.ready;
    assign pslverr         = s.err_resp;
    assign auto_trigger    = s.trig_out;
    assign threshold_event = s.event_out;
endmodule

// >>> verification/adcc_core_model.sv
// behavioural conversion core and trigger sources
`timescale 1ns/100ps
module adcc_core_model (
    // clock
    input wire logic    pclk,
    // conversion core
    output logic        conv_start = 1'b0,
    output logic        conv_done = 1'b0,
    output logic [9:0]  conv_sample = 10'h3ff,
    // trigger source levels
    output logic [31:0] trig_src = 32'h0000_0000
);
    task automatic convert(input logic [9:0] s);
        @(posedge pclk);
        conv_start <= 1'b1;
        @(posedge pclk);
        conv_start <= 1'b0;
        @(posedge pclk);
        conv_done <= 1'b1;
        conv_sample <= s;
        @(posedge pclk);
        conv_done <= 1'b0;
        // sample not held past its valid cycle
        conv_sample <= ~s;
        @(posedge pclk);
    endtask
    task automatic pulse(input logic [4:0] i);
        @(posedge pclk);
        trig_src[i] <= 1'b1;
        repeat (3) @(posedge pclk);
        trig_src[i] <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
endmodule

// >>> verification/adcc_regs_props.sv
// port checks of the computation registers
`timescale 1ns/100ps
`include "adcc_defs.svh"
module adcc_regs_props (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave
    input wire logic [15:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // conversion core and triggers
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic [9:0]  conv_sample,
    input wire logic [31:0] trig_src,
    input wire logic        auto_trigger,
    input wire logic        threshold_event
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] sel_q;
    logic       src_d;
    logic       mapped;
    // holes answer with an error
    assign mapped = paddr[15:2] inside {`ADCC_IDX_TRIG, [`ADCC_IDX_PREV:`ADCC_IDX_RES + 14'h1],
        [`ADCC_IDX_RPT:`ADCC_IDX_FLTR + 14'h1], [`ADCC_IDX_CTRL0:`ADCC_IDX_STAT]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 5'h00;
            src_d <= 1'b0;
        end else begin
            if (psel && penable && pready && pwrite && paddr[15:2] == `ADCC_IDX_TRIG) begin
                sel_q <= pwdata[4:0];
            end
            src_d <= trig_src[sel_q];
        end
    end
    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("no ready");
    AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("ready too long");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("stray ready");
    AST_UNMAPPED_ERR: assert property (psel && !penable && !mapped |=> pslverr)
        else $error("no slave error");
    AST_MAPPED_OK: assert property (psel && !penable && mapped |=> !pslverr)
        else $error("false slave error");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("stray read data");
    AST_EVENT_CAUSE: assert property (threshold_event |-> $past(conv_done))
        else $error("stray event");
    AST_TRIG_CAUSE: assert property (auto_trigger |-> src_d)
        else $error("stray trigger");
    AST_TRIG_EDGE: assert property ($rose(src_d) && $stable(sel_q) |-> auto_trigger)
        else $error("missed trigger");
    AST_RESET_QUIET: assert property ($rose(presetn) |-> !pready && !threshold_event)
        else $error("busy after reset");
    cover property (threshold_event);
    cover property (auto_trigger);
    cover property (pslverr);
endmodule
bind adcc_regs adcc_regs_props u_adcc_regs_props (.*);

// >>> verification/test_adc_computation_result_registers.sv
// bench for the computation registers
`timescale 1ns/100ps
`include "adcc_defs.svh"
module test_adc_computation_result_registers;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, trig_src, rdat;
    logic        pready, pslverr, conv_start, conv_done, auto_trigger, threshold_event, rerr;
    logic [9:0]  conv_sample;
    int          failures = 0, n_compared = 0, n_evt = 0, n_trig = 0, e0;
    adcc_regs u_adcc_regs (.*);
    adcc_core_model u_adcc_core_model (.*);
    always #5 pclk = ~pclk;
    always @(negedge pclk) begin
        n_evt += (threshold_event === 1'b1);
        n_trig += (auto_trigger === 1'b1);
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            print_verdict();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rdat, {24'h00_0000, exp});
    endtask
    task automatic rd16(input logic [13:0] idx, input logic [15:0] v);
        rd(idx, v[7:0]);
        rd(idx + 14'h1, v[15:8]);
    endtask
    task automatic wr16(input logic [13:0] idx, input logic [15:0] v);
        apb(1'b1, idx, v[7:0]);
        apb(1'b1, idx + 14'h1, v[15:8]);
    endtask
    task automatic stat(input logic [7:0] mask, input logic [7:0] exp);
        apb(1'b0, `ADCC_IDX_STAT, 8'h00);
        chk(rdat & {24'h00_0000, mask}, {24'h00_0000, exp});
    endtask
    initial begin
        repeat (50000) @(posedge pclk);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd16(`ADCC_IDX_PREV, 16'h0000);
        rd16(`ADCC_IDX_RES, 16'h0000);
        rd16(`ADCC_IDX_STPT, 16'h0000);
        rd16(`ADCC_IDX_UTH, 16'h0000);
        rd16(`ADCC_IDX_ERR, 16'h0000);
        apb(1'b1, `ADCC_IDX_PREV, 8'hff);
        rd(`ADCC_IDX_PREV, 8'h00);
        apb(1'b0, 14'h0f00, 8'h00);
        chk({31'h0, rerr}, 32'h1);
        wr16(`ADCC_IDX_ACC, 16'hbeef);
        rd16(`ADCC_IDX_ACC, 16'hbeef);
        wr16(`ADCC_IDX_STPT, 16'h0100);
        rd16(`ADCC_IDX_STPT, 16'h0100);
        $display("registers done");
        for (int i = 0; i < 32; i++) begin
            apb(1'b1, `ADCC_IDX_TRIG, 8'(i));
            u_adcc_core_model.pulse(5'(i));
            u_adcc_core_model.pulse(5'(i + 1));
        end
        chk(n_trig, 32'd32);
        $display("triggers done");
        apb(1'b1, `ADCC_IDX_CTRL0, 8'h80);
        u_adcc_core_model.convert(10'h2a5);
        rd16(`ADCC_IDX_RES, 16'h02a5);
        apb(1'b1, `ADCC_IDX_CTRL0, 8'h00);
        u_adcc_core_model.convert(10'h2a5);
        rd16(`ADCC_IDX_RES, 16'ha940);
        rd16(`ADCC_IDX_PREV, 16'h02a5);
        apb(1'b1, `ADCC_IDX_CTRL1, 8'h01);
        apb(1'b1, `ADCC_IDX_CTRL0, 8'hc1);
        wr16(`ADCC_IDX_ACC, 16'h0000);
        u_adcc_core_model.convert(10'h100);
        u_adcc_core_model.convert(10'h100);
        rd16(`ADCC_IDX_ACC, 16'h0200);
        rd16(`ADCC_IDX_FLTR, 16'h0100);
        rd16(`ADCC_IDX_PREV, 16'h0080);
        wr16(`ADCC_IDX_ACC, 16'hffff);
        u_adcc_core_model.convert(10'h001);
        stat(8'h80, 8'h80);
        $display("results done");
        apb(1'b1, `ADCC_IDX_CTRL0, 8'h80);
        apb(1'b1, `ADCC_IDX_CTRL1, 8'h10);
        wr16(`ADCC_IDX_UTH, 16'h0040);
        apb(1'b1, `ADCC_IDX_TMD, 8'h02);
        e0 = n_evt;
        u_adcc_core_model.convert(10'h150);
        rd16(`ADCC_IDX_ERR, 16'h0050);
        stat(8'h60, 8'h40);
        u_adcc_core_model.convert(10'h0f0);
        stat(8'h60, 8'h20);
        chk(n_evt - e0, 32'h1);
        $display("thresholds done");
        apb(1'b1, `ADCC_IDX_RPT, 8'h02);
        apb(1'b1, `ADCC_IDX_CNT, 8'h00);
        apb(1'b1, `ADCC_IDX_CTRL0, 8'h82);
        apb(1'b1, `ADCC_IDX_TMD, 8'h05);
        e0 = n_evt;
        u_adcc_core_model.convert(10'h010);
        rd(`ADCC_IDX_CNT, 8'h01);
        chk(n_evt - e0, 32'h0);
        u_adcc_core_model.convert(10'h010);
        rd(`ADCC_IDX_CNT, 8'h00);
        chk(n_evt - e0, 32'h1);
        apb(1'b1, `ADCC_IDX_CTRL1, 8'h11);
        apb(1'b1, `ADCC_IDX_CTRL0, 8'h84);
        wr16(`ADCC_IDX_ACC, 16'h0100);
        u_adcc_core_model.convert(10'h040);
        rd16(`ADCC_IDX_FLTR, 16'h0060);
        $display("repeat done");
        print_verdict();
    end
endmodule
